/* usbkp_pkg.sv */
package usbkp_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 10;   // byte address width
    localparam int          DATA_W      = 32;   // avalon data width
    localparam int          IDX_LSB     = 2;    // word index starts here
    localparam int          IDX_W       = 8;    // register index width
    localparam int          NUM_SRC     = 4;    // sources in this group
    localparam int          LVL_W       = 2;    // bits per priority level

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_ENABLE     = 8'hB1;
    localparam logic [7:0]  IDX_PRIO_LOW   = 8'hB2;
    localparam logic [7:0]  IDX_PRIO_HIGH  = 8'hB3;
    localparam logic [7:0]  IDX_STATUS     = 8'hB4;

    // ------------------------------------------------------------------
    // field layout shared by enable, low and high registers
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_RESET   = 8'h00; // all sources at level 0
    localparam logic [7:0]  USED_MASK   = 8'h87; // bits 6..3 read as zero

    // source index to register bit: hub 0, func 1, susp 2, kbd 7
    localparam logic [3:0][2:0] SRC_BIT = {3'h7, 3'h2, 3'h1, 3'h0};

    localparam logic [1:0]  SRC_HUB     = 2'h0;
    localparam logic [1:0]  SRC_FUNC    = 2'h1;
    localparam logic [1:0]  SRC_SUSP    = 2'h2;
    localparam logic [1:0]  SRC_KBD     = 2'h3;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int          ST_REQ      = 0;    // request to the core
    localparam int          ST_SRC_LSB  = 1;    // presented source, 2 bits
    localparam int          ST_LVL_LSB  = 3;    // presented level, 2 bits
    localparam int          ST_INS_LSB  = 8;    // in-service levels, 4 bits

    // ------------------------------------------------------------------
    // avalon response codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

    // bus answer sequencer, one-hot
    typedef enum logic [1:0]
    {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } usbkp_bus_state_type;

endpackage : usbkp_pkg

/* usbkp_prio_select.sv */
`timescale 1ns/10ps

// picks the highest-level pending source; ties go to the lowest index
module usbkp_prio_select
#(
    parameter int N_SRC = 4,                    // number of sources
    parameter int L_W   = 2                     // bits per level
)
(
    input  wire logic [N_SRC-1:0]     pending_i, // enabled and pending
    input  wire logic [N_SRC*L_W-1:0] level_i,   // packed levels
    output logic                      any_o,     // some source pending
    output logic [1:0]                src_o,     // winning source
    output logic [L_W-1:0]            level_o    // winning level
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (N_SRC < 1 || N_SRC > 4)
    begin : g_bad_n
        $error("usbkp_prio_select: N_SRC must be 1 to 4");
    end
    if (L_W != 2)
    begin : g_bad_l
        $error("usbkp_prio_select: L_W must be 2");
    end

    // ------------------------------------------------------------------
    // linear scan; strict greater keeps the lower index on a tie
    // ------------------------------------------------------------------
    always_comb
    begin
        any_o   = 1'b0;
        src_o   = 2'h0;
        level_o = '0;
        for (int i = 0; i < N_SRC; i++)
        begin
            if (pending_i[i] &&
                (!any_o || level_i[i*L_W +: L_W] > level_o))
            begin
                any_o   = 1'b1;
                src_o   = 2'(i);
                level_o = level_i[i*L_W +: L_W];
            end
        end
    end

endmodule : usbkp_prio_select

/* usbkp_irq_prio_bank.sv */
`timescale 1ns/10ps

module usbkp_irq_prio_bank
#(
    parameter int ADDR_W = usbkp_pkg::ADDR_W     // byte address width
)
(
    input  wire logic              mclk_i,        // core clock
    input  wire logic              rst_n_i,       // async reset, low
    input  wire logic [ADDR_W-1:0] address_i,     // avalon byte address
    input  wire logic              read_i,        // avalon read
    input  wire logic              write_i,       // avalon write
    input  wire logic [31:0]       writedata_i,   // avalon write data
    input  wire logic [3:0]        byteenable_i,  // avalon byte lanes
    output logic [31:0]            readdata_o,    // avalon read data
    output logic [1:0]             response_o,    // avalon response
    output logic                   waitrequest_o, // avalon stall
    input  wire logic [3:0]        src_pending_i, // source flags
    input  wire logic              irq_ack_i,     // core takes vector
    input  wire logic              irq_return_i,  // core ends service
    output logic                   irq_o,         // request to core
    output logic [1:0]             irq_src_o,     // presented source
    output logic [1:0]             irq_level_o,   // presented level
    output logic [7:0]             prio_level_o   // all levels, packed
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < usbkp_pkg::IDX_LSB + usbkp_pkg::IDX_W)
    begin : g_bad_addr
        $error("usbkp_irq_prio_bank: ADDR_W too small for the map");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    usbkp_pkg::usbkp_bus_state_type bus_state_reg;
    usbkp_pkg::usbkp_bus_state_type bus_state_next;

    logic [7:0]  prio_low_reg;
    logic [7:0]  prio_low_next;
    logic [7:0]  prio_high_reg;
    logic [7:0]  prio_high_next;
    logic [7:0]  enable_reg;
    logic [7:0]  enable_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic [1:0]  response_reg;
    logic [1:0]  response_next;

    logic [3:0]  in_service_reg;
    logic [3:0]  in_service_next;
    logic        irq_reg;
    logic        irq_next;
    logic [1:0]  irq_src_reg;
    logic [1:0]  irq_src_next;
    logic [1:0]  irq_level_reg;
    logic [1:0]  irq_level_next;

    logic [7:0]  reg_index;
    logic        hit_enable;
    logic        hit_low;
    logic        hit_high;
    logic        hit_status;
    logic        hit_any;
    logic        bus_req;
    logic        bus_commit;

    logic [3:0]  src_enabled;
    logic [3:0]  arb_pending;
    logic [7:0]  src_level;
    logic        sel_any;
    logic [1:0]  sel_src;
    logic [1:0]  sel_level;
    logic        run_any;
    logic [1:0]  run_level;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // low two address bits ignored: every register is one aligned word
    assign reg_index  = address_i[usbkp_pkg::IDX_LSB +: usbkp_pkg::IDX_W];
    assign hit_enable = (reg_index == usbkp_pkg::IDX_ENABLE);
    assign hit_low    = (reg_index == usbkp_pkg::IDX_PRIO_LOW);
    assign hit_high   = (reg_index == usbkp_pkg::IDX_PRIO_HIGH);
    assign hit_status = (reg_index == usbkp_pkg::IDX_STATUS);
    assign hit_any    = hit_enable | hit_low | hit_high | hit_status;
    assign bus_req    = read_i | write_i;

    // ------------------------------------------------------------------
    // bus sequencer: one wait cycle, then the answer edge
    // ------------------------------------------------------------------
    // a fixed single wait keeps read data registered without a bypass
    always_comb
    begin
        bus_state_next = bus_state_reg;
        unique case (bus_state_reg)
            usbkp_pkg::BUS_IDLE:
            begin
                if (bus_req)
                begin
                    bus_state_next = usbkp_pkg::BUS_ANSWER;
                end
            end
            usbkp_pkg::BUS_ANSWER:
            begin
                bus_state_next = usbkp_pkg::BUS_IDLE;
            end
            default:
            begin
                bus_state_next = usbkp_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_state_reg <= usbkp_pkg::BUS_IDLE;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
        end
    end

    // stall the first cycle of every request, release in the answer cycle
    assign waitrequest_o = bus_req &
                           (bus_state_reg != usbkp_pkg::BUS_ANSWER);
    assign bus_commit    = bus_state_reg == usbkp_pkg::BUS_ANSWER;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // reserved bits are never stored, so they always read back as zero
    always_comb
    begin
        prio_low_next  = prio_low_reg;
        prio_high_next = prio_high_reg;
        enable_next    = enable_reg;
        if (bus_commit && write_i && byteenable_i[0])
        begin
            if (hit_low)
            begin
                prio_low_next  = writedata_i[7:0] & usbkp_pkg::USED_MASK;
            end
            if (hit_high)
            begin
                prio_high_next = writedata_i[7:0] & usbkp_pkg::USED_MASK;
            end
            if (hit_enable)
            begin
                enable_next    = writedata_i[7:0] & usbkp_pkg::USED_MASK;
            end
        end
    end

    // both priority registers clear on reset: every source at level 0
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prio_low_reg  <= usbkp_pkg::REG_RESET;
            prio_high_reg <= usbkp_pkg::REG_RESET;
            enable_reg    <= usbkp_pkg::REG_RESET;
        end
        else
        begin
            prio_low_reg  <= prio_low_next;
            prio_high_reg <= prio_high_next;
            enable_reg    <= enable_next;
        end
    end

    // ------------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------------
    // captured in the stall cycle so it stands at the answer edge
    always_comb
    begin
        readdata_next = readdata_reg;
        response_next = response_reg;
        if (bus_req && !bus_commit)
        begin
            readdata_next = '0;
            response_next = hit_any ? usbkp_pkg::RESP_OKAY
                                    : usbkp_pkg::RESP_DECERR;
            if (read_i)
            begin
                if (hit_low)
                begin
                    readdata_next[7:0] = prio_low_reg;
                end
                if (hit_high)
                begin
                    readdata_next[7:0] = prio_high_reg;
                end
                if (hit_enable)
                begin
                    readdata_next[7:0] = enable_reg;
                end
                if (hit_status)
                begin
                    readdata_next = status_word;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            readdata_reg <= '0;
            response_reg <= usbkp_pkg::RESP_OKAY;
        end
        else
        begin
            readdata_reg <= readdata_next;
            response_reg <= response_next;
        end
    end

    assign readdata_o = readdata_reg;
    assign response_o = response_reg;

    // ------------------------------------------------------------------
    // per-source level and enable gating
    // ------------------------------------------------------------------
    // source s uses bit SRC_BIT[s]: 0 hub/sof, 1 func, 2 susp, 3 kbd
    for (genvar s = 0; s < usbkp_pkg::NUM_SRC; s++)
    begin : g_src
        // high register bit is the msb of the level
        assign src_level[s*2 +: 2] =
            {prio_high_reg[usbkp_pkg::SRC_BIT[s]],
             prio_low_reg[usbkp_pkg::SRC_BIT[s]]};
        assign src_enabled[s] = enable_reg[usbkp_pkg::SRC_BIT[s]];
        // a source without its enable bit never reaches the selector
        assign arb_pending[s] = src_pending_i[s] & src_enabled[s];
    end

    assign prio_level_o = src_level;

    // ------------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------------
    usbkp_prio_select
    #(
        .N_SRC     (usbkp_pkg::NUM_SRC),
        .L_W       (usbkp_pkg::LVL_W)
    )
    u_select
    (
        .pending_i (arb_pending),
        .level_i   (src_level),
        .any_o     (sel_any),
        .src_o     (sel_src),
        .level_o   (sel_level)
    );

    // running level is the highest level now in service
    always_comb
    begin
        run_any   = |in_service_reg;
        run_level = 2'h0;
        for (int l = 0; l < 4; l++)
        begin
            if (in_service_reg[l])
            begin
                run_level = 2'(l);
            end
        end
    end

    // ------------------------------------------------------------------
    // request to the core and in-service tracking
    // ------------------------------------------------------------------
    // only a strictly higher level may interrupt a running service;
    // a return and an ack in one cycle: the return pops first
    always_comb
    begin
        in_service_next = in_service_reg;
        if (irq_return_i && run_any)
        begin
            in_service_next[run_level] = 1'b0;
        end
        if (irq_ack_i && irq_reg)
        begin
            in_service_next[irq_level_reg] = 1'b1;
        end
        irq_next       = sel_any && (!run_any || sel_level > run_level);
        irq_src_next   = sel_src;
        irq_level_next = sel_level;
        // drop the request the cycle after it is taken
        if (irq_ack_i && irq_reg)
        begin
            irq_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            in_service_reg <= 4'h0;
            irq_reg        <= 1'b0;
            irq_src_reg    <= 2'h0;
            irq_level_reg  <= 2'h0;
        end
        else
        begin
            in_service_reg <= in_service_next;
            irq_reg        <= irq_next;
            irq_src_reg    <= irq_src_next;
            irq_level_reg  <= irq_level_next;
        end
    end

    assign irq_o       = irq_reg;
    assign irq_src_o   = irq_src_reg;
    assign irq_level_o = irq_level_reg;

    // ------------------------------------------------------------------
    // status word for software
    // ------------------------------------------------------------------
    always_comb
    begin
        status_word = '0;
        status_word[usbkp_pkg::ST_REQ]           = irq_reg;
        status_word[usbkp_pkg::ST_SRC_LSB +: 2]  = irq_src_reg;
        status_word[usbkp_pkg::ST_LVL_LSB +: 2]  = irq_level_reg;
        status_word[usbkp_pkg::ST_INS_LSB +: 4]  = in_service_reg;
    end

endmodule : usbkp_irq_prio_bank

/* usbkp_irq_prio_bank_chk.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------------
// protocol and priority checker, sees only the bank's ports
// ------------------------------------------------------------------
module usbkp_irq_prio_bank_chk
#(
    parameter int ADDR_W = 10                      // byte address width
)
(
    input  wire logic              mclk_i,        // core clock
    input  wire logic              rst_n_i,       // async reset, low
    input  wire logic [ADDR_W-1:0] address_i,     // avalon byte address
    input  wire logic              read_i,        // avalon read
    input  wire logic              write_i,       // avalon write
    input  wire logic [31:0]       writedata_i,   // avalon write data
    input  wire logic [3:0]        byteenable_i,  // avalon byte lanes
    input  wire logic [31:0]       readdata_o,    // avalon read data
    input  wire logic [1:0]        response_o,    // avalon response
    input  wire logic              waitrequest_o, // avalon stall
    input  wire logic [3:0]        src_pending_i, // source flags
    input  wire logic              irq_ack_i,     // core takes vector
    input  wire logic              irq_return_i,  // core ends service
    input  wire logic              irq_o,         // request to core
    input  wire logic [1:0]        irq_src_o,     // presented source
    input  wire logic [1:0]        irq_level_o,   // presented level
    input  wire logic [7:0]        prio_level_o   // all levels, packed
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // a completed write with lane 0 on, to one register index
    sequence wr_done(logic [7:0] idx);
        write_i && !waitrequest_o && byteenable_i[0]
            && address_i[9:2] == idx;
    endsequence

    // ------------------------------------------------------------------
    // bus answer and decode
    // ------------------------------------------------------------------
    req_stall_a : assert property (
        $rose(read_i) |-> waitrequest_o)
        else $error("read not stalled in its first cycle");
    one_wait_a : assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("stall lasted more than one cycle");
    decode_err_a : assert property (
        read_i && !waitrequest_o
            && !(address_i[9:2] inside {8'hB1, 8'hB2, 8'hB3, 8'hB4})
        |-> response_o == 2'h3 && readdata_o == 32'h0)
        else $error("unmapped read not refused");

    // ------------------------------------------------------------------
    // priority levels
    // ------------------------------------------------------------------
    reset_zero_a : assert property (
        $rose(rst_n_i) |-> prio_level_o == 8'h00)
        else $error("levels not zero after reset");
    lo_map_a : assert property (
        wr_done(8'hB2) |=> {prio_level_o[6], prio_level_o[4],
            prio_level_o[2], prio_level_o[0]}
            == $past({writedata_i[7], writedata_i[2:0]}))
        else $error("low register bits not at level lsb");
    hi_map_a : assert property (
        wr_done(8'hB3) |=> {prio_level_o[7], prio_level_o[5],
            prio_level_o[3], prio_level_o[1]}
            == $past({writedata_i[7], writedata_i[2:0]}))
        else $error("high register bits not at level msb");
    hold_lvl_a : assert property (
        !(write_i && !waitrequest_o) |=> $stable(prio_level_o))
        else $error("levels changed without a write");

    // ------------------------------------------------------------------
    // request to the core
    // ------------------------------------------------------------------
    ack_drop_a : assert property (
        irq_o && irq_ack_i |=> !irq_o)
        else $error("request stayed up after ack");
    src_pend_a : assert property (
        irq_o |-> (($past(src_pending_i) >> irq_src_o) & 4'h1) != 4'h0)
        else $error("presented source was not pending");
    lvl_match_a : assert property (
        irq_o && $stable(prio_level_o)
        |-> irq_level_o == prio_level_o[2*irq_src_o +: 2])
        else $error("presented level differs from source level");

endmodule : usbkp_irq_prio_bank_chk

/* usbkp_core_model.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------------
// stand-in for the core's interrupt handler and firmware
// ------------------------------------------------------------------
module usbkp_core_model
(
    input  wire logic       mclk_i,   // core clock
    input  wire logic       rst_n_i,  // async reset, low
    input  wire logic       irq_i,    // request from the bank
    input  wire logic       ack_en_i, // core accepts requests
    input  wire logic [3:0] dly_i,    // cycles before the ack
    input  wire logic       done_i,   // firmware ends service
    output logic            ack_o,    // vector taken, pulse
    output logic            ret_o     // service end, pulse
);
    logic [3:0] cnt_reg;

    // ack after a chosen delay, one cycle only so the request can drop
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= 4'h0;
            ack_o   <= 1'h0;
            ret_o   <= 1'h0;
        end
        else
        begin
            ret_o <= done_i;     // return only when firmware says so
            if (ack_o || !(irq_i && ack_en_i))
            begin
                ack_o   <= 1'h0;
                cnt_reg <= 4'h0;
            end
            else if (cnt_reg == dly_i)
                ack_o <= 1'h1;
            else
                cnt_reg <= cnt_reg + 4'h1;
        end
    end

endmodule : usbkp_core_model

/* tb_usbkp_irq_prio_bank.sv */
`timescale 1ns/10ps

module tb_usbkp_irq_prio_bank;
    logic        mclk_i, rst_n_i, read_i, write_i, ack_en, done;
    logic        waitrequest_o, irq_ack_i, irq_return_i, irq_o;
    logic [9:0]  address_i;
    logic [31:0] writedata_i, readdata_o, rd;
    logic [3:0]  byteenable_i, src_pending_i, dly;
    logic [1:0]  response_o, irq_src_o, irq_level_o, rs;
    logic [7:0]  prio_level_o, lo, hi, en;
    int          err_total, comparisons, i, s, best, win;
    int          bpos[4] = '{0, 1, 2, 7};

    // ------------------------------------------------------------------
    // clock, design and partner
    // ------------------------------------------------------------------
    initial
    begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end

    usbkp_irq_prio_bank #(.ADDR_W(10)) usbkp_irq_prio_bank_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .response_o(response_o), .waitrequest_o(waitrequest_o),
        .src_pending_i(src_pending_i), .irq_ack_i(irq_ack_i),
        .irq_return_i(irq_return_i), .irq_o(irq_o),
        .irq_src_o(irq_src_o), .irq_level_o(irq_level_o),
        .prio_level_o(prio_level_o));

    usbkp_core_model usbkp_core_model_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .irq_i(irq_o),
        .ack_en_i(ack_en), .dly_i(dly), .done_i(done),
        .ack_o(irq_ack_i), .ret_o(irq_return_i));

    // ------------------------------------------------------------------
    // reporting and bus tasks
    // ------------------------------------------------------------------
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp,
             input string what);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : chk

    // request held until the edge at which waitrequest is seen low
    task bus(input logic wr, input logic [7:0] idx,
             input logic [7:0] wd, input logic be0);
        int n;
        @(posedge mclk_i);
        address_i    <= {idx, 2'h0};
        read_i       <= !wr;
        write_i      <= wr;
        writedata_i  <= {24'h0, wd};
        byteenable_i <= {3'h7, be0};
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (waitrequest_o !== 1'h0 && n < 40);
        if (waitrequest_o !== 1'h0)
        begin
            err_total++;
            print_verdict;
        end
        rd = readdata_o;
        rs = response_o;
        read_i  <= 1'h0;
        write_i <= 1'h0;
    endtask : bus

    // expected packed levels, high bit over low bit
    function logic [7:0] exp_pl();
        for (int k = 0; k < 4; k++)
            exp_pl[2*k +: 2] = {hi[bpos[k]], lo[bpos[k]]};
    endfunction : exp_pl

    task set_pend(input logic [3:0] p, input int n);
        @(posedge mclk_i);
        src_pending_i <= p;
        repeat (n) @(negedge mclk_i);
    endtask : set_pend

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n_i, read_i, write_i, ack_en, done} = 5'h0;
        {address_i, writedata_i, byteenable_i, src_pending_i} = '0;
        {err_total, comparisons} = 0;
        dly = 4'h0;
        void'($urandom(42));
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        bus(0, 8'hB2, 8'h00, 1); chk(rd, 32'h0, "low reset");
        chk(rs, 2'h0, "okay");
        bus(0, 8'hB3, 8'h00, 1); chk(rd, 32'h0, "high reset");
        chk(prio_level_o, 8'h00, "reset levels");
        bus(0, 8'hA0, 8'h00, 1); chk(rs, 2'h3, "unmapped");
        $display("test reset done");

        for (i = 0; i < 8; i++)
        begin
            lo = 8'($urandom) & 8'h87;
            hi = 8'($urandom) & 8'h87;
            bus(1, 8'hB2, lo, 1);
            bus(1, 8'hB3, hi, 1);
            bus(1, 8'hB3, ~hi & 8'h87, 0);
            bus(0, 8'hB2, 8'h00, 1); chk(rd, {24'h0, lo}, "low");
            bus(0, 8'hB3, 8'h00, 1); chk(rd, {24'h0, hi}, "high");
            chk(prio_level_o, exp_pl(), "levels");
        end
        $display("test mapping done");

        for (i = 0; i < 16; i++)
        begin
            en = 8'($urandom) & 8'h87;
            bus(1, 8'hB1, en, 1);
            set_pend(4'($urandom), 3);
            best = -1;
            for (s = 0; s < 4; s++)
                if (en[bpos[s]] && src_pending_i[s]
                    && int'(exp_pl() >> 2*s) % 4 > best)
                begin
                    best = int'(exp_pl() >> 2*s) % 4;
                    win  = s;
                end
            chk(irq_o, best >= 0, "request");
            if (best >= 0)
                chk({irq_src_o, irq_level_o}, win*4 + best, "winner");
        end
        $display("test arbitration done");

        set_pend(4'h0, 1);
        lo = 8'h81;
        hi = 8'h80;
        bus(1, 8'hB1, 8'h87, 1);
        bus(1, 8'hB2, lo, 1);
        bus(1, 8'hB3, hi, 1);
        dly <= 4'($urandom % 4);
        ack_en <= 1'h1;
        set_pend(4'h1, 8);
        ack_en = 1'h0;
        chk(irq_o, 1'h0, "acked");
        @(posedge mclk_i);
        done <= 1'h1;
        @(posedge mclk_i);
        done <= 1'h0;
        repeat (3) @(negedge mclk_i);
        chk({irq_o, irq_src_o, irq_level_o}, 5'h11, "returned");
        ack_en = 1'h1;
        repeat (8) @(negedge mclk_i);
        ack_en = 1'h0;
        set_pend(4'h3, 3);
        chk(irq_o, 1'h0, "lower held");
        set_pend(4'hB, 3);
        chk({irq_o, irq_src_o, irq_level_o}, 5'h1F, "preempt");
        bus(0, 8'hB4, 8'h00, 1); chk(rd, 32'h21F, "status");
        $display("test preemption done");
        print_verdict;
    end

    // bound on the whole run
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        print_verdict;
    end
endmodule : tb_usbkp_irq_prio_bank

bind usbkp_irq_prio_bank usbkp_irq_prio_bank_chk #(.ADDR_W(ADDR_W)) chk_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .response_o(response_o), .waitrequest_o(waitrequest_o),
    .src_pending_i(src_pending_i), .irq_ack_i(irq_ack_i),
    .irq_return_i(irq_return_i), .irq_o(irq_o), .irq_src_o(irq_src_o),
    .irq_level_o(irq_level_o), .prio_level_o(prio_level_o));
